// File: src/wst_pkg.sv
`default_nettype none
// ****************************************************************
// constants of the weld status process image
// ****************************************************************
package wst_pkg;

  // ****************************************************************
  // process-image addresses
  // ****************************************************************
  localparam logic [15:0] STAT_G1 = 16'hF100; // always reserved
  localparam logic [15:0] STAT_G2 = 16'hF101; // readiness, arc, range errors
  localparam logic [15:0] STAT_G3 = 16'hF102; // welding mode and image
  localparam logic [15:0] STAT_G4 = 16'hF103; // stabilizers, contact faults
  localparam logic [15:0] STAT_G5 = 16'hF104; // sensors and safety
  localparam logic [15:0] STAT_G6 = 16'hF105; // limit, sync, mains, warning
  localparam logic [15:0] STAT_G7 = 16'hF106; // always reserved
  localparam logic [15:0] STAT_G8 = 16'hF107; // mirrored option inputs
  localparam int NUM_WORDS = 8; // consecutive status words
  localparam logic [15:0] STAT_RESET = 16'h0000; // every word after reset

  // ****************************************************************
  // robot control word fields
  // ****************************************************************
  localparam int CTL_MODE_LSB = 0; // five-bit working-mode field
  localparam int CTL_CMDSEL_BIT = 14; // command value selection
  localparam logic [4:0] MODE_CODE_IPS = 5'h00; // internal parameter selection
  localparam logic [4:0] MODE_CODE_SPECIAL2 = 5'h01; // special two-step
  localparam logic [4:0] MODE_CODE_JOB = 5'h02; // job mode
  localparam logic [4:0] MODE_CODE_TWO_STEP = 5'h08; // two-step characteristics
  localparam logic [4:0] MODE_CODE_MANUAL2 = 5'h09; // two-step manual
  localparam logic [4:0] MODE_CODE_STOP_COOL = 5'h11; // stop cooling unit
  localparam logic [4:0] WELD_MODE_MAX = 5'h08; // highest defined process code

  // ****************************************************************
  // status word bit positions
  // ****************************************************************
  localparam int G2_HEARTBEAT = 0;
  localparam int G2_CMD_OOR = 10;
  localparam int G2_CORR_OOR = 11;
  localparam int G3_PARAM_INT = 8;
  localparam int G3_CHAR_VALID = 9;
  localparam int G3_IMAGE_B0 = 14;
  localparam int G3_IMAGE_B1 = 15;
  localparam int G4_SHORT_TIP = 14;
  localparam int G4_NOZZLE = 15;
  localparam int G5_SENSOR4 = 4;
  localparam int G5_SAFETY_LSB = 11;
  localparam int G5_NOTIFY = 14;
  localparam int G5_NOT_READY = 15;
  localparam int G6_LIMIT = 0;
  localparam int G6_TANDEM_SYNC = 9;
  localparam int G6_MAINS = 10;
  localparam int G6_WARNING = 14;

  // ****************************************************************
  // power-source pin positions in the packed input vector
  // ****************************************************************
  localparam int SP_G2_LO = 0; // 6 bits: word2 bits 1..5 and touch
  localparam int SP_TORCHBODY = 6;
  localparam int SP_PROC_ACT = 7;
  localparam int SP_MOTION_REL = 8;
  localparam int SP_WIRE_STICK = 9;
  localparam int SP_WELD_MODE = 10; // 5 bits
  localparam int SP_PARAM_INT = 15;
  localparam int SP_CHAR_VALID = 16;
  localparam int SP_RETROFIT = 17;
  localparam int SP_STAB = 18; // 2 bits: penetration, arc length
  localparam int SP_SHORT_TIP = 20;
  localparam int SP_NOZZLE = 21;
  localparam int SP_SENSOR = 22; // 4 bits
  localparam int SP_SAFETY = 26; // 2 bits
  localparam int SP_NOTIFY = 28;
  localparam int SP_NOT_READY = 29;
  localparam int SP_LIMIT = 30;
  localparam int SP_TANDEM = 31;
  localparam int SP_MAINS = 32;
  localparam int SP_WARNING = 33;
  localparam int SP_OPT_IN = 34; // 8 bits
  localparam int SP_RUNNING = 42;
  localparam int SRC_W = 43;

  // ****************************************************************
  // timing and value limits
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HB_HALF_PERIOD_MS = 500; // half of the 1 Hz period
  localparam int unsigned HB_HALF_CYCLES = HB_HALF_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [15:0] FEED_MIN = 16'h0000; // 0.00 m/min
  localparam logic [15:0] FEED_MAX = 16'h2710; // 100.00 m/min
  localparam logic [15:0] CUR_MIN = 16'h0000; // 0.0 A
  localparam logic [15:0] CUR_MAX = 16'h7FFF; // 3276.7 A
  localparam logic [15:0] CORR_MIN = 16'hFF9C; // -10.0
  localparam logic [15:0] CORR_MAX = 16'h0064; // +10.0

  // decoded robot working mode
  typedef enum logic [2:0] {
    WM_IPS = 3'h0,
    WM_SPECIAL2 = 3'h1,
    WM_JOB = 3'h2,
    WM_TWO_STEP = 3'h3,
    WM_MANUAL2 = 3'h4,
    WM_STOP_COOL = 3'h5,
    WM_UNDEF = 3'h6
  } wst_work_mode_t;

endpackage : wst_pkg
`default_nettype wire

// File: src/wst_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// raw and synchronised power-source pins
// ****************************************************************
interface wst_sync_if #(
  parameter int W = 43
);
  logic [W-1:0] raw; // straight from the pins
  logic [W-1:0] synced; // after two flip-flops
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface : wst_sync_if
`default_nettype wire

// File: src/wst_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// two-stage synchroniser bank for the power-source pins
// ****************************************************************
module wst_pin_sync #(
  parameter int W = 43
) (
  input wire logic clock,
  input wire logic reset,
  wst_sync_if.sync_side pins
);

  logic [W-1:0] meta_q; // first stage, read only by the second stage
  logic [W-1:0] sync_q; // second stage, safe to use

  // one pair of flops per pin
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pins.raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign pins.synced = sync_q;

endmodule : wst_pin_sync
`default_nettype wire

// File: src/wst_status_image.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - zero selects internal parameters, 00010 job
// - codes 00001,01000,01001,10001 decode; others undefined
// - control bit 14 picks feeder or current
// - eight status words at F100 to F107
// - word F101 bit 10: command out of range
// - word F101 bit 11: correction out of range
// - F103 bit14 tip short, bit15 nozzle
// - F104 bits 0-2 sensors, 11-12 safety
// - F104 bit 4 carries sensor four
// - five welding-mode bits report active process
// - image bits read 00 standard, 10 retrofit
// - safety field two bits, passed through
module wst_status_image #(
  parameter int unsigned HB_HALF = wst_pkg::HB_HALF_CYCLES, // cycles per heartbeat level
  parameter int SRC_W = wst_pkg::SRC_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [SRC_W-1:0] src_pins,
  input wire logic [15:0] ctl_word,
  input wire logic [15:0] cmd_value,
  input wire logic [15:0] arc_corr,
  input wire logic [15:0] pulse_corr,
  input wire logic pd_cycle,
  input wire logic pd_rd,
  input wire logic [15:0] pd_addr,
  output logic pd_rvalid_q,
  output logic [15:0] pd_rdata_q,
  output logic pd_err_q,
  output wst_pkg::wst_work_mode_t work_mode_q,
  output logic mode_undef_q,
  output logic cmd_is_current_q,
  output logic heartbeat_q
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  // pins come from another domain, so each crosses
  // two flops before any decode reads it
  wst_sync_if #(.W(SRC_W)) sync_bus ();
  logic [SRC_W-1:0] s; // synchronised pins

  assign sync_bus.raw = src_pins;
  assign s = sync_bus.synced;

  // one flop pair per pin
  wst_pin_sync #(.W(SRC_W)) u_sync (
    .clock(clock),
    .reset(reset),
    .pins(sync_bus)
  );

  // ****************************************************************
  // working-mode and command selection decode
  // ****************************************************************
  logic [4:0] mode_field; // robot working-mode field
  wst_pkg::wst_work_mode_t mode_d;

  // mode field sits in the low five bits
  assign mode_field = ctl_word[wst_pkg::CTL_MODE_LSB +: 5];

  // plain table lookup; unlisted codes fall to undefined
  always_comb begin
    case (mode_field)
      wst_pkg::MODE_CODE_IPS: mode_d = wst_pkg::WM_IPS;
      wst_pkg::MODE_CODE_JOB: mode_d = wst_pkg::WM_JOB;
      wst_pkg::MODE_CODE_SPECIAL2: mode_d = wst_pkg::WM_SPECIAL2;
      wst_pkg::MODE_CODE_TWO_STEP: mode_d = wst_pkg::WM_TWO_STEP;
      wst_pkg::MODE_CODE_MANUAL2: mode_d = wst_pkg::WM_MANUAL2;
      wst_pkg::MODE_CODE_STOP_COOL: mode_d = wst_pkg::WM_STOP_COOL;
      default: mode_d = wst_pkg::WM_UNDEF;
    endcase
  end

  // decoded mode follows the control word every cycle
  // same clock as the robot side, no synchroniser
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      // reset leaves internal parameter selection
      work_mode_q <= wst_pkg::WM_IPS;
      mode_undef_q <= 1'b0;
      cmd_is_current_q <= 1'b0;
    end else begin
      // all three outputs move together, one cycle late
      work_mode_q <= mode_d;
      mode_undef_q <= (mode_d == wst_pkg::WM_UNDEF);
      cmd_is_current_q <= ctl_word[wst_pkg::CTL_CMDSEL_BIT];
    end
  end

  // ****************************************************************
  // set-value range checks
  // ****************************************************************
  logic cmd_oor; // command outside the window of its meaning
  logic corr_oor; // either correction outside plus or minus ten
  // window bounds for the selected meaning
  logic [15:0] cmd_lo;
  logic [15:0] cmd_hi;

  // the window depends on how the command value is interpreted
  always_comb begin
    if (ctl_word[wst_pkg::CTL_CMDSEL_BIT]) begin
      // welding current: positive half of the word
      cmd_lo = wst_pkg::CUR_MIN;
      cmd_hi = wst_pkg::CUR_MAX;
    end else begin
      // wire feeder: zero up to the feeder ceiling
      cmd_lo = wst_pkg::FEED_MIN;
      cmd_hi = wst_pkg::FEED_MAX;
    end
    // signed compare: a negative command is out of range
    cmd_oor = ($signed(cmd_value) < $signed(cmd_lo)) ||
              ($signed(cmd_value) > $signed(cmd_hi));
    // one flag for both corrections; the robot cannot tell which
    corr_oor = ($signed(arc_corr) < $signed(wst_pkg::CORR_MIN)) ||
               ($signed(arc_corr) > $signed(wst_pkg::CORR_MAX)) ||
               ($signed(pulse_corr) < $signed(wst_pkg::CORR_MIN)) ||
               ($signed(pulse_corr) > $signed(wst_pkg::CORR_MAX));
  end

  // ****************************************************************
  // heartbeat
  // ****************************************************************
  logic [31:0] hb_cnt_q; // cycles spent in the current level

  // stopped source holds the beat low so a dead link is visible
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hb_cnt_q <= 32'h00000000;
      heartbeat_q <= 1'b0;
    // stopped: clear, so a restart begins a full half period
    end else if (!s[wst_pkg::SP_RUNNING]) begin
      hb_cnt_q <= 32'h00000000;
      heartbeat_q <= 1'b0;
    // running: flip the beat at the end of each half period
    end else if (hb_cnt_q == HB_HALF - 1) begin
      hb_cnt_q <= 32'h00000000;
      heartbeat_q <= ~heartbeat_q;
    end else begin
      // still inside the current level
      hb_cnt_q <= hb_cnt_q + 32'h00000001;
    end
  end

  // ****************************************************************
  // status word assembly
  // ****************************************************************
  logic [15:0] words_d [wst_pkg::NUM_WORDS];
  logic [15:0] words_q [wst_pkg::NUM_WORDS];
  logic [4:0] weld_mode; // only defined process codes pass

  // unknown process codes read as internal mode selection
  assign weld_mode = (s[wst_pkg::SP_WELD_MODE +: 5] > wst_pkg::WELD_MODE_MAX) ?
                     5'h00 : s[wst_pkg::SP_WELD_MODE +: 5];

  // reserved bits stay zero; groups one and seven carry nothing
  always_comb begin
    for (int w = 0; w < wst_pkg::NUM_WORDS; w++) begin
      words_d[w] = wst_pkg::STAT_RESET;
    end
    // group two: readiness, arc, range errors
    words_d[1][wst_pkg::G2_HEARTBEAT] = heartbeat_q;
    words_d[1][6:1] = s[wst_pkg::SP_G2_LO +: 6];
    // touch rides on pin five; bit six stays reserved
    words_d[1][8] = s[wst_pkg::SP_G2_LO + 5];
    words_d[1][6] = 1'b0;
    words_d[1][9] = s[wst_pkg::SP_TORCHBODY];
    words_d[1][wst_pkg::G2_CMD_OOR] = cmd_oor;
    words_d[1][wst_pkg::G2_CORR_OOR] = corr_oor;
    words_d[1][12] = s[wst_pkg::SP_PROC_ACT];
    words_d[1][13] = s[wst_pkg::SP_MOTION_REL];
    words_d[1][14] = s[wst_pkg::SP_WIRE_STICK];
    // group three: process, selection flags, image
    words_d[2][4:0] = weld_mode;
    words_d[2][wst_pkg::G3_PARAM_INT] = s[wst_pkg::SP_PARAM_INT];
    words_d[2][wst_pkg::G3_CHAR_VALID] = s[wst_pkg::SP_CHAR_VALID];
    words_d[2][wst_pkg::G3_IMAGE_B0] = 1'b0;
    words_d[2][wst_pkg::G3_IMAGE_B1] = s[wst_pkg::SP_RETROFIT];
    // group four: stabilizers and contact faults
    words_d[3][1:0] = s[wst_pkg::SP_STAB +: 2];
    words_d[3][wst_pkg::G4_SHORT_TIP] = s[wst_pkg::SP_SHORT_TIP];
    words_d[3][wst_pkg::G4_NOZZLE] = s[wst_pkg::SP_NOZZLE];
    // group five: sensors, safety field, notices
    words_d[4][2:0] = s[wst_pkg::SP_SENSOR +: 3];
    words_d[4][wst_pkg::G5_SENSOR4] = s[wst_pkg::SP_SENSOR + 3];
    words_d[4][wst_pkg::G5_SAFETY_LSB +: 2] = s[wst_pkg::SP_SAFETY +: 2];
    words_d[4][wst_pkg::G5_NOTIFY] = s[wst_pkg::SP_NOTIFY];
    words_d[4][wst_pkg::G5_NOT_READY] = s[wst_pkg::SP_NOT_READY];
    // group six: limit, sync, mains, warning
    words_d[5][wst_pkg::G6_LIMIT] = s[wst_pkg::SP_LIMIT];
    words_d[5][wst_pkg::G6_TANDEM_SYNC] = s[wst_pkg::SP_TANDEM];
    words_d[5][wst_pkg::G6_MAINS] = s[wst_pkg::SP_MAINS];
    words_d[5][wst_pkg::G6_WARNING] = s[wst_pkg::SP_WARNING];
    // group eight: option inputs, one to one
    words_d[7][7:0] = s[wst_pkg::SP_OPT_IN +: 8];
  end

  // all eight words are captured on the same edge, so a read between
  // cycles never sees a half-updated image; the price is up to one
  // process-data cycle of extra latency
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      // reset empties the whole image
      for (int w = 0; w < wst_pkg::NUM_WORDS; w++) begin
        words_q[w] <= wst_pkg::STAT_RESET;
      end
    // strobe: every word from the same cycle
    end else if (pd_cycle) begin
      for (int w = 0; w < wst_pkg::NUM_WORDS; w++) begin
        words_q[w] <= words_d[w];
      end
    end
  end

  // ****************************************************************
  // process-data read port
  // ****************************************************************
  logic addr_hit; // address inside F100..F107

  assign addr_hit = (pd_addr[15:3] == wst_pkg::STAT_G1[15:3]);

  // answer one cycle after the read request; unmapped reads give zero and an error
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pd_rvalid_q <= 1'b0;
      pd_rdata_q <= wst_pkg::STAT_RESET;
      pd_err_q <= 1'b0;
    // mapped: word chosen by the low address bits
    end else if (pd_rd && addr_hit) begin
      pd_rvalid_q <= 1'b1;
      pd_rdata_q <= words_q[pd_addr[2:0]];
      pd_err_q <= 1'b0;
    // outside the block: refuse with zero data
    end else if (pd_rd) begin
      pd_rvalid_q <= 1'b1;
      pd_rdata_q <= wst_pkg::STAT_RESET;
      pd_err_q <= 1'b1;
    end else begin
      // idle: zero data, so a stray sample shows nothing
      pd_rvalid_q <= 1'b0;
      pd_rdata_q <= wst_pkg::STAT_RESET;
      pd_err_q <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  job_decode_a: assert property (@(posedge clock) disable iff (reset)
    (mode_field == 5'h02) |=> (work_mode_q == wst_pkg::WM_JOB))
    else $error("job code not decoded");
  cool_decode_a: assert property (@(posedge clock) disable iff (reset)
    (mode_field == 5'h11) |=> (work_mode_q == wst_pkg::WM_STOP_COOL) && !mode_undef_q)
    else $error("stop cooling code not decoded");
  cmd_select_a: assert property (@(posedge clock) disable iff (reset)
    ##1 (cmd_is_current_q == $past(ctl_word[14])))
    else $error("command selection not followed");
  unmapped_read_a: assert property (@(posedge clock) disable iff (reset)
    (pd_rd && (pd_addr[15:3] != 13'h1E20)) |=> pd_rvalid_q && pd_err_q && (pd_rdata_q == 16'h0000))
    else $error("unmapped read not refused");
  cmd_range_a: assert property (@(posedge clock) disable iff (reset)
    (pd_cycle && !ctl_word[14] && ($signed(cmd_value) > 16'sh2710)) |=> words_q[1][10])
    else $error("feeder command over range not flagged");
  corr_range_a: assert property (@(posedge clock) disable iff (reset)
    (pd_cycle && ($signed(arc_corr) < -16'sd100)) |=> words_q[1][11])
    else $error("correction under range not flagged");
  contact_bits_a: assert property (@(posedge clock) disable iff (reset)
    pd_cycle |=> (words_q[3][15:14] == $past(s[21:20])))
    else $error("contact faults not reported");
  sensor_bits_a: assert property (@(posedge clock) disable iff (reset)
    pd_cycle |=> (words_q[4][2:0] == $past(s[24:22])) && (words_q[4][4] == $past(s[25])))
    else $error("sensor bits not reported");
  hb_period_a: assert property (@(posedge clock) disable iff (reset)
    $changed(heartbeat_q) && s[42] && $past(s[42]) |-> $past(hb_cnt_q) == HB_HALF - 1)
    else $error("heartbeat toggled at the wrong time");
  image_hold_a: assert property (@(posedge clock) disable iff (reset)
    !pd_cycle |=> $stable(words_q[1]) && $stable(words_q[4]) && $stable(words_q[7]))
    else $error("status word changed outside a cycle");
  image_code_a: assert property (@(posedge clock) disable iff (reset)
    (words_q[2][14] == 1'b0) && (words_q[0] == 16'h0000) && (words_q[6] == 16'h0000))
    else $error("illegal image code or reserved word set");
  read_answer_a: assert property (@(posedge clock) disable iff (reset)
    ##1 (pd_rvalid_q == $past(pd_rd)))
    else $error("read not answered in one cycle");
  weld_clamp_a: assert property (@(posedge clock) disable iff (reset)
    (pd_cycle && (s[14:10] > 5'h08)) |=> (words_q[2][4:0] == 5'h00))
    else $error("undefined process code passed");
  safety_field_a: assert property (@(posedge clock) disable iff (reset)
    pd_cycle |=> (words_q[4][12:11] == $past(s[27:26])))
    else $error("safety field not passed through");
  beat_idle_a: assert property (@(posedge clock) disable iff (reset)
    !s[42] |=> !heartbeat_q)
    else $error("heartbeat ran while stopped");

endmodule : wst_status_image
`default_nettype wire

// File: verification/wst_robot_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// robot controller model: drives control words, strobes and reads
// ****************************************************************
module wst_robot_model (
  input wire logic clock,
  output logic [15:0] ctl_word,
  output logic [15:0] cmd_value,
  output logic [15:0] arc_corr,
  output logic [15:0] pulse_corr,
  output logic pd_cycle,
  output logic pd_rd,
  output logic [15:0] pd_addr,
  input wire logic pd_rvalid_q,
  input wire logic [15:0] pd_rdata_q,
  input wire logic pd_err_q
);
  // idle state at time zero
  initial begin
    ctl_word = 16'h0000;
    cmd_value = 16'h0000;
    arc_corr = 16'h0000;
    pulse_corr = 16'h0000;
    pd_cycle = 1'h0;
    pd_rd = 1'h0;
    pd_addr = 16'h0000;
  end

  // control words change just after an edge; mode codes come from the bench table
  task automatic drive(input logic [15:0] ctl, input logic [15:0] cmd,
                       input logic [15:0] arc, input logic [15:0] pls);
    @(posedge clock);
    #1;
    ctl_word = ctl;
    cmd_value = cmd;
    arc_corr = arc;
    pulse_corr = pls;
  endtask : drive

  // one-cycle process-data strobe
  task automatic snap();
    @(posedge clock);
    #1;
    pd_cycle = 1'h1;
    @(posedge clock);
    #1;
    pd_cycle = 1'h0;
  endtask : snap

  // one read, optionally with a snapshot in the same cycle; answer one cycle on
  task automatic rd(input logic [15:0] a, input logic with_snap, output logic [15:0] d,
                    output logic v, output logic e);
    @(posedge clock);
    #1;
    pd_rd = 1'h1;
    pd_addr = a;
    pd_cycle = with_snap;
    @(posedge clock);
    #1;
    pd_rd = 1'h0;
    pd_cycle = 1'h0;
    // a released address never keeps the old value, so a stale decode shows up
    pd_addr = ~a;
    v = pd_rvalid_q;
    d = pd_rdata_q;
    e = pd_err_q;
  endtask : rd
endmodule : wst_robot_model
`default_nettype wire

// File: verification/weld_status_process_image_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module weld_status_process_image_tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic [42:0] src_pins = 43'h0; // power-source pin levels
  logic [42:0] pins; // pattern under test
  logic [15:0] ctl_word, cmd_value, arc_corr, pulse_corr, pd_addr, pd_rdata_q, d;
  logic pd_cycle, pd_rd, pd_rvalid_q, pd_err_q, mode_undef_q, cmd_is_current_q, heartbeat_q;
  logic v, e;
  wst_pkg::wst_work_mode_t work_mode_q;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  // mode table: code, expected decode, undefined flag
  logic [4:0] mc [9] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h09, 5'h11, 5'h03, 5'h1F, 5'h10};
  logic [2:0] me [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6};
  // pin patterns with forced weld-mode field (safety field covers all four codes)
  logic [42:0] pat [4] = '{43'h3FF_FFFF_FFFF, 43'h155_5555_5555, 43'h0AA_AAAA_AAAA,
                           43'h0F0_F0F0_F0F0};
  logic [4:0] wm [4] = '{5'h1F, 5'h08, 5'h07, 5'h00};
  // range table: select, command, corrections, expected {corr, cmd} flags
  logic rs [7] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0};
  logic [15:0] rc [7] = '{16'h2710, 16'h2711, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h0000, 16'h0000};
  logic [15:0] ra [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0065, 16'h0000, 16'hFF9B};
  logic [15:0] rp [7] = '{16'h0000, 16'h0000, 16'h0000, 16'hFF9C, 16'h0000, 16'hFF9B, 16'h0000};
  logic [1:0] rx [7] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h3, 2'h2, 2'h2};

  // 100 MHz clock
  always #5 clock = ~clock;

  // ****************************************************************
  // instances
  // ****************************************************************
  wst_status_image #(.HB_HALF(8)) i_dut (
    .clock(clock), .reset(reset), .src_pins(src_pins), .ctl_word(ctl_word),
    .cmd_value(cmd_value), .arc_corr(arc_corr), .pulse_corr(pulse_corr),
    .pd_cycle(pd_cycle), .pd_rd(pd_rd), .pd_addr(pd_addr), .pd_rvalid_q(pd_rvalid_q),
    .pd_rdata_q(pd_rdata_q), .pd_err_q(pd_err_q), .work_mode_q(work_mode_q),
    .mode_undef_q(mode_undef_q), .cmd_is_current_q(cmd_is_current_q),
    .heartbeat_q(heartbeat_q));
  wst_robot_model i_robot (
    .clock(clock), .ctl_word(ctl_word), .cmd_value(cmd_value), .arc_corr(arc_corr),
    .pulse_corr(pulse_corr), .pd_cycle(pd_cycle), .pd_rd(pd_rd), .pd_addr(pd_addr),
    .pd_rvalid_q(pd_rvalid_q), .pd_rdata_q(pd_rdata_q), .pd_err_q(pd_err_q));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // expected word from pins; out-of-range mode codes read as zero
  function automatic logic [15:0] exp_word(input logic [15:0] a, input logic [42:0] p);
    logic [4:0] m;
    m = (p[14:10] > 5'h08) ? 5'h00 : p[14:10];
    case (a)
      16'hF101: exp_word = {1'h0, p[9:7], 2'h0, p[6:5], 2'h0, p[4:0], 1'h0};
      16'hF102: exp_word = {p[17], 1'h0, 4'h0, p[16:15], 3'h0, m};
      16'hF103: exp_word = {p[21:20], 12'h000, p[19:18]};
      16'hF104: exp_word = {p[29:28], 1'h0, p[27:26], 6'h00, p[25], 1'h0, p[24:22]};
      16'hF105: exp_word = {1'h0, p[33], 3'h0, p[32:31], 8'h00, p[30]};
      16'hF107: exp_word = {8'h00, p[41:34]};
      default: exp_word = 16'h0000; // reserved words and unmapped places
    endcase
  endfunction : exp_word

  // compare of any value up to one word wide
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // read one place and check handshake, error flag and data
  task automatic read_chk(input logic [15:0] a, input logic [15:0] ex);
    logic bad;
    bad = (a < 16'hF100) || (a > 16'hF107);
    i_robot.rd(a, 1'h0, d, v, e);
    chk({15'h0, v}, 16'h0001, "rvalid");
    chk({15'h0, e}, {15'h0, bad}, "err");
    chk(d, bad ? 16'h0000 : ex, "rdata");
  endtask : read_chk

  // single place where the run ends
  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clock);
    #1;
    reset = 1'h0;
    // all words read zero before any snapshot; unmapped places refused
    for (int i = 0; i < 8; i++) read_chk(16'hF100 + 16'(i), 16'h0000);
    read_chk(16'hF108, 16'h0000);
    read_chk(16'h0000, 16'h0000);
    // mode decode and command selection, one cycle after the control word
    for (int i = 0; i < 9; i++) begin
      i_robot.drive({1'h0, i[0], 9'h000, mc[i]}, 16'h0000, 16'h0000, 16'h0000);
      @(posedge clock);
      #1;
      chk({13'h0, work_mode_q}, {13'h0, me[i]}, "mode");
      chk({15'h0, mode_undef_q}, {15'h0, me[i] == 3'h6}, "undef");
      chk({15'h0, cmd_is_current_q}, {15'h0, i[0]}, "cmdsel");
    end
    i_robot.drive(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    // pin mapping of every word; pins settle through the synchroniser first
    for (int i = 0; i < 4; i++) begin
      pins = pat[i];
      pins[14:10] = wm[i];
      src_pins = pins;
      repeat (4) @(posedge clock);
      #1;
      i_robot.snap();
      for (int a = 0; a < 8; a++) begin
        read_chk(16'hF100 + 16'(a), exp_word(16'hF100 + 16'(a), pins));
      end
    end
    // a read taken with the snapshot strobe still sees the old word
    src_pins = 43'h0;
    repeat (4) @(posedge clock);
    #1;
    i_robot.rd(16'hF101, 1'h1, d, v, e);
    chk(d, exp_word(16'hF101, pins), "old word");
    read_chk(16'hF101, 16'h0000);
    // range flags against both meanings of the command value
    for (int i = 0; i < 7; i++) begin
      i_robot.drive({1'h0, rs[i], 14'h0000}, rc[i], ra[i], rp[i]);
      i_robot.snap();
      read_chk(16'hF101, {4'h0, rx[i], 10'h000});
    end
    // a second reset clears the image
    reset = 1'h1;
    repeat (2) @(posedge clock);
    #1;
    reset = 1'h0;
    read_chk(16'hF101, 16'h0000);
    // heartbeat: eight cycles per level with the shortened count, stops when idle
    src_pins = 43'h400_0000_0000;
    k = 0;
    while (heartbeat_q !== 1'h1 && k < 40) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk({15'h0, heartbeat_q}, 16'h0001, "beat rise");
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (heartbeat_q === 1'h1 && k < 40);
    chk(16'(k), 16'h0008, "beat half");
    src_pins = 43'h0;
    repeat (25) @(posedge clock);
    #1;
    chk({15'h0, heartbeat_q}, 16'h0000, "beat idle");
    stop_test();
  end
endmodule : weld_status_process_image_tb_top
`default_nettype wire
